// ---- design/tcw_defs.vh ----
/*
 * Constants of the waveform-mode timer channel: register offsets, field
 * positions, reset values and codes. Assumes an 8-bit AXI4-Lite byte address.
 */
`ifndef TCW_DEFS_VH
`define TCW_DEFS_VH

`define TCW_OFS_CMD     8'h00
`define TCW_OFS_MODE    8'h04
`define TCW_OFS_COUNT   8'h10
`define TCW_OFS_CMPA    8'h14
`define TCW_OFS_CMPB    8'h18
`define TCW_OFS_TOP     8'h1C
`define TCW_OFS_STAT    8'h20

`define TCW_F_CLKSEL    2:0
`define TCW_F_INV       3
`define TCW_F_GATE      5:4
`define TCW_F_STOP      6
`define TCW_F_HALT      7
`define TCW_F_EVEDGE    9:8
`define TCW_F_EVSRC     11:10
`define TCW_F_RESTART   12
`define TCW_F_UPDOWN    13
`define TCW_F_RETRIG    14
`define TCW_F_WAVE      15
`define TCW_F_A_MATCH   17:16
`define TCW_F_A_TOP     19:18
`define TCW_F_A_EVENT   21:20
`define TCW_F_A_SOFT    23:22
`define TCW_F_B_MATCH   25:24
`define TCW_F_B_TOP     27:26
`define TCW_F_B_EVENT   29:28
`define TCW_F_B_SOFT    31:30

`define TCW_CMD_EN      0
`define TCW_CMD_DIS     1
`define TCW_CMD_SOFT    2

`define TCW_RST_MODE    32'h00000000
`define TCW_RST_VAL     16'h0000
`define TCW_RST_FLAGS   8'h00
`define TCW_CNT_MAX     16'hFFFF

`define TCW_ACT_SET     2'h1
`define TCW_ACT_CLR     2'h2
`define TCW_ACT_TGL     2'h3

`define TCW_RESP_OKAY   2'h0
`define TCW_RESP_SLVERR 2'h2

`endif

// ---- design/tcw_channel.v ----
/*
 * One 16-bit timer channel in waveform mode with its registers behind an
 * AXI4-Lite slave. Assumes clock, external clock and line inputs arrive from
 * pins; the capture load pulses and captured value come from CORE_CLK logic.
 */
// The placing of the registers and register access over AXI4-Lite were decided locally.
`include "tcw_defs.vh"

module tcw_channel (
    // Clock, reset and enable
    input  wire        CORE_CLK,
    input  wire        RSTN,
    input  wire        CE,
    // AXI4-Lite write address
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output wire        AWREADY,
    // AXI4-Lite write data
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output wire        WREADY,
    // AXI4-Lite write response
    output wire [1:0]  BRESP,
    output wire        BVALID,
    input  wire        BREADY,
    // AXI4-Lite read address
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output wire        ARREADY,
    // AXI4-Lite read data
    output wire [31:0] RDATA,
    output wire [1:0]  RRESP,
    output wire        RVALID,
    input  wire        RREADY,
    // Clock sources from pins
    input  wire [4:0]  PRESCALED_CLK,
    input  wire [2:0]  EXT_CLOCK,
    // Capture loads
    input  wire        LOAD_A,
    input  wire        LOAD_B,
    input  wire [15:0] CAPTURE_VALUE,
    // Waveform lines
    input  wire        WAVE_LINE_A_I,
    output wire        WAVE_LINE_A_O,
    output wire        WAVE_LINE_A_OE,
    input  wire        WAVE_LINE_B_I,
    output wire        WAVE_LINE_B_O,
    output wire        WAVE_LINE_B_OE
);

    reg  [9:0]  sync1_reg;
    reg  [9:0]  sync2_reg;
    reg         gclk_prev_reg;
    reg         ev_prev_reg;
    reg  [31:0] mode_reg;
    reg  [15:0] count_reg;
    reg  [15:0] cmpa_reg;
    reg  [15:0] cmpb_reg;
    reg  [15:0] top_reg;
    reg         dir_reg;
    reg         clk_en_reg;
    reg         stop_reg;
    reg  [7:0]  flag_reg;
    reg         unread_a_reg;
    reg         unread_b_reg;
    reg         wave_a_reg;
    reg         wave_b_reg;
    reg         oe_a_reg;
    reg         oe_b_reg;
    reg         awready_reg;
    reg         wready_reg;
    reg         aw_full_reg;
    reg         w_full_reg;
    reg  [7:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         bvalid_reg;
    reg  [1:0]  bresp_reg;
    reg         arready_reg;
    reg         rvalid_reg;
    reg  [31:0] rdata_reg;
    reg  [1:0]  rresp_reg;

    reg  [15:0] count_next;
    reg         dir_next;
    reg         clk_en_next;
    reg         stop_next;
    reg  [1:0]  code_a;
    reg  [1:0]  code_b;
    reg  [31:0] rd_data;
    reg         rd_ok;
    reg  [7:0]  flag_set;

    // Synchronised pins: [4:0] prescaled clocks, [7:5] ext clocks, [8] line A, [9] line B.
    wire [2:0]  ext_sync = sync2_reg[7:5];
    wire        pin_a = sync2_reg[8];
    wire        pin_b = sync2_reg[9];
    wire        wave_mode = mode_reg[`TCW_F_WAVE];
    wire [1:0]  gate_sel = mode_reg[`TCW_F_GATE];
    wire [1:0]  ev_src = mode_reg[`TCW_F_EVSRC];
    wire [1:0]  ev_edge = mode_reg[`TCW_F_EVEDGE];
    wire        b_drives = ev_src != 2'h0;

    wire        gate_ok = (gate_sel == 2'h0) | ext_sync[gate_sel - 2'h1];
    wire        sel_clk = sync2_reg[mode_reg[`TCW_F_CLKSEL]];
    wire        gclk = sel_clk & gate_ok;
    wire        clk_edge = mode_reg[`TCW_F_INV] ? (gclk_prev_reg & ~gclk) : (~gclk_prev_reg & gclk);
    wire        tick = clk_edge & clk_en_reg & ~stop_reg;

    wire        ev_level = b_drives ? ext_sync[ev_src - 2'h1] : pin_b;
    wire        ev_rise = ev_level & ~ev_prev_reg;
    wire        ev_fall = ~ev_level & ev_prev_reg;
    wire        ext_ev = wave_mode & ((ev_edge[0] & ev_rise) | (ev_edge[1] & ev_fall));
    wire        restart = ext_ev & mode_reg[`TCW_F_RESTART];

    // Write path: address and data may arrive in either order.
    wire        wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [31:0] wnew_mode = (mode_reg & ~wmask) | (w_data_reg & wmask);
    wire [15:0] wnew_a = (cmpa_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
    wire [15:0] wnew_b = (cmpb_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
    wire [15:0] wnew_top = (top_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
    wire        wr_cmd = wr_go & (aw_addr_reg == `TCW_OFS_CMD) & w_strb_reg[0];
    wire        cmd_en = wr_cmd & w_data_reg[`TCW_CMD_EN];
    wire        cmd_dis = wr_cmd & w_data_reg[`TCW_CMD_DIS];
    wire        soft_trig = wr_cmd & w_data_reg[`TCW_CMD_SOFT];
    wire        trig = soft_trig | restart;
    wire        wr_map = (aw_addr_reg == `TCW_OFS_CMD) | (aw_addr_reg == `TCW_OFS_MODE) |
                         (aw_addr_reg == `TCW_OFS_COUNT) | (aw_addr_reg == `TCW_OFS_CMPA) |
                         (aw_addr_reg == `TCW_OFS_CMPB) | (aw_addr_reg == `TCW_OFS_TOP) |
                         (aw_addr_reg == `TCW_OFS_STAT);

    wire        rd_go = ARVALID & arready_reg;
    wire        rd_stat = rd_go & (ARADDR == `TCW_OFS_STAT);
    wire        rd_cmpa = rd_go & (ARADDR == `TCW_OFS_CMPA);
    wire        rd_cmpb = rd_go & (ARADDR == `TCW_OFS_CMPB);

    // Events are judged on the value the count is about to take.
    wire        counted = tick & ~trig;
    wire        hit_a = counted & (count_next == cmpa_reg);
    wire        hit_b = counted & (count_next == cmpb_reg);
    wire        hit_top = counted & (count_next == top_reg);
    wire        ovf = counted & ~mode_reg[`TCW_F_UPDOWN] & (count_reg == `TCW_CNT_MAX) & (count_next == `TCW_RST_VAL);

    function wave_apply;
        input       cur;
        input [1:0] code;
        begin
            case (code)
                `TCW_ACT_SET: wave_apply = 1'b1;
                `TCW_ACT_CLR: wave_apply = 1'b0;
                `TCW_ACT_TGL: wave_apply = ~cur;
                default:      wave_apply = cur;
            endcase
        end
    endfunction

    // Count sequence per profile.
    always @* begin
        count_next = count_reg;
        dir_next = dir_reg;
        if (trig) begin
            count_next = `TCW_RST_VAL;
            dir_next = 1'b0;
        end else if (tick) begin
            if (mode_reg[`TCW_F_UPDOWN]) begin
                if (!dir_reg) begin
                    if (count_reg == (mode_reg[`TCW_F_RETRIG] ? top_reg : `TCW_CNT_MAX)) begin
                        dir_next = 1'b1;
                        count_next = count_reg - 16'h0001;
                    end else begin
                        count_next = count_reg + 16'h0001;
                    end
                end else begin
                    if (count_reg == `TCW_RST_VAL) begin
                        dir_next = 1'b0;
                        count_next = 16'h0001;
                    end else begin
                        count_next = count_reg - 16'h0001;
                    end
                end
            end else if (mode_reg[`TCW_F_RETRIG] && count_reg == top_reg) begin
                count_next = `TCW_RST_VAL;
            end else begin
                count_next = count_reg + 16'h0001;
            end
        end
    end

    // Clock enable and stop; a disable command outranks everything else.
    always @* begin
        clk_en_next = clk_en_reg;
        stop_next = stop_reg;
        if (trig) begin
            stop_next = 1'b0;
        end else if (hit_top && mode_reg[`TCW_F_STOP]) begin
            stop_next = 1'b1;
        end
        if (cmd_dis) begin
            clk_en_next = 1'b0;
        end else if (trig || cmd_en) begin
            clk_en_next = 1'b1;
        end else if (hit_top && mode_reg[`TCW_F_HALT]) begin
            clk_en_next = 1'b0;
        end
    end

    // Only the highest-priority event acts: soft trigger, then event, then top, then match.
    always @* begin
        code_a = 2'h0;
        code_b = 2'h0;
        if (hit_a && mode_reg[`TCW_F_A_MATCH] != 2'h0) code_a = mode_reg[`TCW_F_A_MATCH];
        if (hit_top && mode_reg[`TCW_F_A_TOP] != 2'h0) code_a = mode_reg[`TCW_F_A_TOP];
        if (ext_ev && mode_reg[`TCW_F_A_EVENT] != 2'h0) code_a = mode_reg[`TCW_F_A_EVENT];
        if (soft_trig && mode_reg[`TCW_F_A_SOFT] != 2'h0) code_a = mode_reg[`TCW_F_A_SOFT];
        if (hit_b && mode_reg[`TCW_F_B_MATCH] != 2'h0) code_b = mode_reg[`TCW_F_B_MATCH];
        if (hit_top && mode_reg[`TCW_F_B_TOP] != 2'h0) code_b = mode_reg[`TCW_F_B_TOP];
        if (ext_ev && mode_reg[`TCW_F_B_EVENT] != 2'h0) code_b = mode_reg[`TCW_F_B_EVENT];
        if (soft_trig && mode_reg[`TCW_F_B_SOFT] != 2'h0) code_b = mode_reg[`TCW_F_B_SOFT];
    end

    // Event flags, bit order: overflow, overrun, match A, match B, top, load A, load B, ext trigger.
    always @* begin
        flag_set = 8'h00;
        flag_set[0] = ovf;
        flag_set[1] = ~wave_mode & ((LOAD_A & unread_a_reg) | (LOAD_B & unread_b_reg));
        flag_set[2] = wave_mode & hit_a;
        flag_set[3] = wave_mode & hit_b & b_drives;
        flag_set[4] = hit_top;
        flag_set[5] = ~wave_mode & LOAD_A;
        flag_set[6] = ~wave_mode & LOAD_B;
        flag_set[7] = ext_ev;
    end

    // Read multiplexer.
    always @* begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        case (ARADDR)
            `TCW_OFS_CMD:   rd_data = 32'h00000000;
            `TCW_OFS_MODE:  rd_data = mode_reg;
            `TCW_OFS_COUNT: rd_data = {16'h0000, count_reg};
            `TCW_OFS_CMPA:  rd_data = {16'h0000, cmpa_reg};
            `TCW_OFS_CMPB:  rd_data = {16'h0000, cmpb_reg};
            `TCW_OFS_TOP:   rd_data = {16'h0000, top_reg};
            `TCW_OFS_STAT: begin
                rd_data[7:0] = flag_reg;
                rd_data[16] = clk_en_reg;
                rd_data[17] = wave_mode ? wave_a_reg : pin_a;
                rd_data[18] = (wave_mode && b_drives) ? wave_b_reg : pin_b;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            sync1_reg <= 10'h000;
            sync2_reg <= 10'h000;
            gclk_prev_reg <= 1'b0;
            ev_prev_reg <= 1'b0;
            mode_reg <= `TCW_RST_MODE;
            count_reg <= `TCW_RST_VAL;
            cmpa_reg <= `TCW_RST_VAL;
            cmpb_reg <= `TCW_RST_VAL;
            top_reg <= `TCW_RST_VAL;
            dir_reg <= 1'b0;
            clk_en_reg <= 1'b0;
            stop_reg <= 1'b0;
            flag_reg <= `TCW_RST_FLAGS;
            unread_a_reg <= 1'b0;
            unread_b_reg <= 1'b0;
            wave_a_reg <= 1'b0;
            wave_b_reg <= 1'b0;
            oe_a_reg <= 1'b0;
            oe_b_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `TCW_RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `TCW_RESP_OKAY;
        end else if (CE) begin
            sync1_reg <= {WAVE_LINE_B_I, WAVE_LINE_A_I, EXT_CLOCK, PRESCALED_CLK};
            sync2_reg <= sync1_reg;
            gclk_prev_reg <= gclk;
            ev_prev_reg <= ev_level;
            count_reg <= count_next;
            dir_reg <= dir_next;
            clk_en_reg <= clk_en_next;
            stop_reg <= stop_next;
            // Set wins over the read clear, so an event during the read is kept.
            flag_reg <= (flag_reg & ~{8{rd_stat}}) | flag_set;
            if (wave_mode) begin
                wave_a_reg <= wave_apply(wave_a_reg, code_a);
                if (b_drives) begin
                    wave_b_reg <= wave_apply(wave_b_reg, code_b);
                end
            end
            oe_a_reg <= wave_mode;
            oe_b_reg <= wave_mode & b_drives;
            unread_a_reg <= (~wave_mode & LOAD_A) | (unread_a_reg & ~rd_cmpa);
            unread_b_reg <= (~wave_mode & LOAD_B) | (unread_b_reg & ~rd_cmpb);
            if (AWVALID && awready_reg) begin
                aw_addr_reg <= AWADDR;
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (WVALID && wready_reg) begin
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_map ? `TCW_RESP_OKAY : `TCW_RESP_SLVERR;
                if (aw_addr_reg == `TCW_OFS_MODE) mode_reg <= wnew_mode;
                if (aw_addr_reg == `TCW_OFS_TOP) top_reg <= wnew_top;
            end
            if (bvalid_reg && BREADY) begin
                bvalid_reg <= 1'b0;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
            // Capture loads and software writes to the compare registers share a path.
            if (!wave_mode && LOAD_A) begin
                cmpa_reg <= CAPTURE_VALUE;
            end else if (wr_go && wave_mode && aw_addr_reg == `TCW_OFS_CMPA) begin
                cmpa_reg <= wnew_a;
            end
            if (!wave_mode && LOAD_B) begin
                cmpb_reg <= CAPTURE_VALUE;
            end else if (wr_go && wave_mode && aw_addr_reg == `TCW_OFS_CMPB) begin
                cmpb_reg <= wnew_b;
            end
            if (rd_go) begin
                rdata_reg <= rd_data;
                rresp_reg <= rd_ok ? `TCW_RESP_OKAY : `TCW_RESP_SLVERR;
                rvalid_reg <= 1'b1;
                arready_reg <= 1'b0;
            end
            if (rvalid_reg && RREADY) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    assign AWREADY = awready_reg;
    assign WREADY = wready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    assign WAVE_LINE_A_O = wave_a_reg;
    assign WAVE_LINE_A_OE = oe_a_reg;
    assign WAVE_LINE_B_O = wave_b_reg;
    assign WAVE_LINE_B_OE = oe_b_reg;

endmodule

// ---- sim/tcw_channel_sva.sv ----
/* Checker of the channel's bus and line A ports.
   Assumes the defines header is on the path. */
`include "tcw_defs.vh"
module tcw_channel_sva (
    // Clock, reset and enable
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    input wire logic        CE,
    // Write channels
    input wire logic [7:0]  AWADDR,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0]  WSTRB,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        BREADY,
    // Read channels
    input wire logic [7:0]  ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    input wire logic        RREADY,
    // Line A
    input wire logic        WAVE_LINE_A_O,
    input wire logic        WAVE_LINE_A_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    wire         aw_hit = AWVALID && AWREADY && WVALID && WREADY && CE;
    wire         ar_hit = ARVALID && ARREADY && CE;
    logic [15:0] top_shadow;
    // The shadow only follows full-strobe writes, which is all the bench issues.
    always @(posedge CORE_CLK) begin
        if (!RSTN) top_shadow <= 16'h0000;
        else if (aw_hit && AWADDR == `TCW_OFS_TOP && WSTRB == 4'hF) top_shadow <= WDATA[15:0];
    end
    property p_cnt; ar_hit && ARADDR == `TCW_OFS_COUNT |=> RVALID && RDATA[31:16] == 16'h0000; endproperty
    a_cnt: assert property (p_cnt) else $error("count upper bits set");
    property p_top; ar_hit && ARADDR == `TCW_OFS_TOP |=> RDATA == {16'h0000, top_shadow}; endproperty
    a_top: assert property (p_top) else $error("top compare readback wrong");
    property p_mir; ar_hit && ARADDR == `TCW_OFS_STAT && WAVE_LINE_A_OE |=> RDATA[17] == $past(WAVE_LINE_A_O); endproperty
    a_mir: assert property (p_mir) else $error("line A mirror wrong");
    property p_unm; ar_hit && ARADDR == 8'h08 |=> RRESP == `TCW_RESP_SLVERR && RDATA == 32'h00000000; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not refused");
    property p_bresp; aw_hit |-> ##[1:2] BVALID; endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");
    property p_bdone; BVALID && BREADY && CE |=> !BVALID && AWREADY && WREADY; endproperty
    a_bdone: assert property (p_bdone) else $error("write not closed");
    property p_busy; BVALID |-> !AWREADY && !WREADY; endproperty
    a_busy: assert property (p_busy) else $error("write taken while busy");
    property p_rdone; RVALID && RREADY && CE |=> !RVALID && ARREADY; endproperty
    a_rdone: assert property (p_rdone) else $error("read not closed");
    c_stat: cover property (ar_hit && ARADDR == `TCW_OFS_STAT);
    c_line: cover property ($rose(WAVE_LINE_A_O));
    c_top: cover property (ar_hit && ARADDR == `TCW_OFS_TOP);
endmodule

bind tcw_channel tcw_channel_sva u_sva (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .WAVE_LINE_A_O(WAVE_LINE_A_O), .WAVE_LINE_A_OE(WAVE_LINE_A_OE));

// ---- sim/tcw_pins.sv ----
/* Pin-side model: free-running prescaled clocks, the event line and both lines.
   Assumes the bench commands the event level. */
module tcw_pins (
    // Event level from the bench
    input  wire logic       ev_level,
    // Channel line outputs
    input  wire logic       a_o,
    input  wire logic       a_oe,
    input  wire logic       b_o,
    input  wire logic       b_oe,
    // Pin levels to the channel
    output logic      [4:0] presc,
    output wire logic [2:0] ext,
    output wire logic       a_i,
    output wire logic       b_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // An 82 ns period keeps the source out of phase with the core clock.
    initial presc = 5'h00;
    always #41 presc = ~presc;
    assign ext = {2'h0, ev_level};
    // A released line falls to its pull-down, never the last driven level.
    assign a_i = a_oe ? a_o : 1'b0;
    assign b_i = b_oe ? b_o : 1'b0;
endmodule

// ---- sim/timer_channel_waveform_regs_tb_top.sv ----
/* Bench of the timer channel over its bus.
   Assumes the header, pin model and checker are compiled. */
`include "tcw_defs.vh"
module timer_channel_waveform_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, ev, load_a, bready, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic        a_o, a_oe, b_o, b_oe, a_i, b_i;
    logic [4:0]  presc;
    logic [2:0]  ext;
    int          bad_count, n_tests;

    tcw_channel dut (
        .CORE_CLK(clk), .RSTN(rstn), .CE(1'b1), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .PRESCALED_CLK(presc), .EXT_CLOCK(ext),
        .LOAD_A(load_a), .LOAD_B(1'b0), .CAPTURE_VALUE(16'h0000), .WAVE_LINE_A_I(a_i),
        .WAVE_LINE_A_O(a_o), .WAVE_LINE_A_OE(a_oe), .WAVE_LINE_B_I(b_i), .WAVE_LINE_B_O(b_o),
        .WAVE_LINE_B_OE(b_oe));
    tcw_pins u_pins (.ev_level(ev), .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe),
        .presc(presc), .ext(ext), .a_i(a_i), .b_i(b_i));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (bvalid) begin
                chk({30'h0, bresp}, {30'h0, er});
                return;
            end
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        bad_count++;
        conclude();
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (rvalid) begin
                d = rdata;
                chk({30'h0, rresp}, {30'h0, er});
                return;
            end
            if (arready) arvalid <= 1'b0;
        end
        bad_count++;
        conclude();
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        rd_reg(a, v, `TCW_RESP_OKAY);
        chk(v & m, e);
    endtask

    task automatic t_reset;
        rchk(`TCW_OFS_MODE, 32'hFFFFFFFF, `TCW_RST_MODE);
        rchk(`TCW_OFS_STAT, 32'hFFFFFFFF, 32'h00000000);
        rd_reg(8'h08, rd, `TCW_RESP_SLVERR);
        chk(rd, 32'h00000000);
        wr(8'h0C, 32'h12345678, `TCW_RESP_SLVERR);
    endtask

    task automatic t_regs;
        wr(`TCW_OFS_CMPA, 32'h00001234, `TCW_RESP_OKAY);
        rchk(`TCW_OFS_CMPA, 32'hFFFFFFFF, 32'h00000000);
        wr(`TCW_OFS_TOP, 32'hABCD0003, `TCW_RESP_OKAY);
        rchk(`TCW_OFS_TOP, 32'hFFFFFFFF, 32'h00000003);
        wr(`TCW_OFS_COUNT, 32'h00000077, `TCW_RESP_OKAY);
        rchk(`TCW_OFS_COUNT, 32'hFFFFFFFF, 32'h00000000);
        wr(`TCW_OFS_MODE, 32'h00008000, `TCW_RESP_OKAY);
        rchk(`TCW_OFS_MODE, 32'hFFFFFFFF, 32'h00008000);
        wr(`TCW_OFS_CMPA, 32'h00000002, `TCW_RESP_OKAY);
        rchk(`TCW_OFS_CMPA, 32'hFFFFFFFF, 32'h00000002);
        rchk(`TCW_OFS_TOP, 32'hFFFFFFFF, 32'h00000003);
    endtask

    // Soft trigger clears line A, top match sets A and toggles B, then the clock halts or stops.
    task automatic t_top(input logic stop);
        logic [31:0] hi;
        hi = {13'h0, ~stop, 1'b1, stop, 16'h0000};
        wr(`TCW_OFS_MODE, stop ? 32'h0C848440 : 32'h0C848480, `TCW_RESP_OKAY);
        rd_reg(`TCW_OFS_STAT, rd, `TCW_RESP_OKAY);
        wr(`TCW_OFS_CMD, 32'h00000004, `TCW_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk({31'h0, a_o}, 32'h00000000);
        repeat (200) @(posedge clk);
        rchk(`TCW_OFS_COUNT, 32'hFFFFFFFF, 32'h00000003);
        rchk(`TCW_OFS_STAT, 32'hFFFFFFFF, hi | 32'h00000014);
        rchk(`TCW_OFS_STAT, 32'hFFFFFFFF, hi);
        chk({29'h0, a_oe, b_oe, b_o}, {29'h0, 2'h3, ~stop});
    endtask

    task automatic t_event;
        logic [31:0] c0;
        wr(`TCW_OFS_MODE, 32'h00908500, `TCW_RESP_OKAY);
        wr(`TCW_OFS_CMD, 32'h00000004, `TCW_RESP_OKAY);
        repeat (60) @(posedge clk);
        wr(`TCW_OFS_CMD, 32'h00000002, `TCW_RESP_OKAY);
        rd_reg(`TCW_OFS_COUNT, c0, `TCW_RESP_OKAY);
        rchk(`TCW_OFS_STAT, 32'h00030000, 32'h00000000);
        load_a <= 1'b1;
        ev <= 1'b1;
        @(posedge clk);
        load_a <= 1'b0;
        repeat (20) @(posedge clk);
        rchk(`TCW_OFS_STAT, 32'h000300A0, 32'h00020080);
        rchk(`TCW_OFS_COUNT, 32'hFFFFFFFF, c0);
        ev <= 1'b0;
        wr(`TCW_OFS_MODE, 32'h00909500, `TCW_RESP_OKAY);
        repeat (5) @(posedge clk);
        rchk(`TCW_OFS_STAT, 32'h00010080, 32'h00000000);
        ev <= 1'b1;
        repeat (20) @(posedge clk);
        rchk(`TCW_OFS_STAT, 32'h00010080, 32'h00010080);
        rchk(`TCW_OFS_STAT, 32'h00010080, 32'h00010000);
    endtask

    initial begin
        rstn = 1'b0;
        ev = 1'b0;
        load_a = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        bad_count = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_top(1'b0);
        t_top(1'b1);
        t_event();
        conclude();
    end
endmodule
